//--- logic/buck_startup_latchoff_sequencer.sv
// start-up, slew and current-limit latchoff sequencer for a multiphase buck
`timescale 1ns/1ps
`include "buck_seq_defs.svh"

// Notes on behaviour
// - first delay starts only when enable high and supply lockout clear.
// - oscillator runs only after first delay completes.
// - first four oscillator cycles blank PWM and detect populated phases.
// - after delay and detection, soft-start ramps toward boot level.
// - delay timer held at zero while disabled.
// - every start-up delay ends at timer threshold; one timer serves all delays.
// - ramp near boot level starts boot hold delay.
// - after boot hold, ramp moves to code-selected level either way.
// - after final delay, code steps slew at five times soft-start rate.
// - disable at any time clears timer and ramp.
// - above current limit, error amplifier level is clamped.
// - limit after final delay starts latchoff delay; expiry shuts down.
// - latchoff timer charges at quarter rate, threshold ends it.
// - limit during start-up waits until final delay completes.
// - switching continues during latchoff; fault clearing resets timer.
// - latched state cleared only by supply loss or enable low.
// - eight-bit voltage code selects the reference target.
// - load release from error amplifier asserts release output.
// - two or three phases, one PWM enable output each.
// - enable low disables PWM and holds power good low.
// - disable forces PWM, power good and driver enable low.
module buck_startup_latchoff_sequencer #(
	parameter int OSC_DIV     = `OSC_DIV_DEFAULT,
	parameter int CODE_W      = `CODE_WIDTH,
	parameter int TIMER_W     = 12,
	parameter logic [11:0] TIMER_THRESH = `TIMER_THRESH_DEF,
	parameter logic [7:0]  BOOT_LEVEL   = `BOOT_LEVEL_DEF,
	parameter logic [7:0]  BOOT_WINDOW  = `BOOT_WINDOW_DEF
) (
	input  wire logic              clk_sys,
	input  wire logic              rst,
	input  wire logic              enableIn,
	input  wire logic              supplyLockout,
	input  wire logic [CODE_W-1:0] voltageIdCode,
	input  wire logic [2:0]        phaseSensed,
	input  wire logic              overCurrent,
	input  wire logic              loadRelease,
	input  wire logic              outputInRange,
	input  wire logic [2:0]        pwmDemand,
	output logic [2:0]             pwmEnable,
	output logic [1:0]             phaseCount,
	output logic [CODE_W-1:0]      softStartRamp,
	output logic                   errorAmpClamp,
	output logic                   loadReleaseDetect,
	output logic                   powerGoodOut,
	output logic                   driverEnableOut,
	output logic                   latchedOff
);
	logic enabled;
	buck_seq_pkg::seq_state_e state_r;
	buck_seq_pkg::seq_state_e state_nxt;
	logic [TIMER_W-1:0] timer_r;
	logic [2:0] blank_r;
	logic [1:0] phases_r;
	logic oscTick;
	logic oscRun;
	logic timerDone;
	logic rampNearBoot;
	logic rampAtTarget;
	logic timerRun;
	logic [2:0] rampStep;
	logic [CODE_W-1:0] rampTarget;
	logic rampClear;
	logic switching;

	function automatic logic [1:0] count_phases(input logic [2:0] s);
		count_phases = s[2] ? `MAX_PHASES : `MIN_PHASES;
	endfunction

	assign enabled = enableIn && !supplyLockout;

	assign oscRun = enabled && (state_r != buck_seq_pkg::ST_OFF)
		&& (state_r != buck_seq_pkg::ST_DELAY1) && (state_r != buck_seq_pkg::ST_LATCHED);

	osc_enable_divider #(
		.DIV(OSC_DIV)
	) u_div (
		.clk_sys(clk_sys),
		.rst    (rst),
		.run    (oscRun),
		.oscTick(oscTick)
	);

	assign timerDone = (timer_r >= TIMER_THRESH);
	assign timerRun = (state_r == buck_seq_pkg::ST_DELAY1) || (state_r == buck_seq_pkg::ST_DELAY3)
		|| (state_r == buck_seq_pkg::ST_DELAY5) || (state_r == buck_seq_pkg::ST_LATCHDLY);

	always_ff @(posedge clk_sys) begin
		if (rst || !enabled || !timerRun || (state_nxt != state_r)) begin
			timer_r <= '0;
		end else if (!timerDone) begin
			if (state_r == buck_seq_pkg::ST_LATCHDLY) begin
				timer_r <= timer_r + TIMER_W'(`DELAY_RATE_LATCH);
			end else begin
				timer_r <= timer_r + TIMER_W'(`DELAY_RATE_START);
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst || !enabled) begin
			blank_r <= 3'h0;
			phases_r <= `MIN_PHASES;
		end else if (state_r == buck_seq_pkg::ST_DETECT && oscTick) begin
			blank_r <= blank_r + 3'h1;
			phases_r <= count_phases(phaseSensed);
		end
	end

	assign rampNearBoot = (softStartRamp + BOOT_WINDOW >= BOOT_LEVEL);
	assign rampAtTarget = (softStartRamp == voltageIdCode);

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			buck_seq_pkg::ST_OFF: begin
				state_nxt = buck_seq_pkg::ST_DELAY1;
			end
			buck_seq_pkg::ST_DELAY1: begin
				if (timerDone) begin
					state_nxt = buck_seq_pkg::ST_DETECT;
				end
			end
			buck_seq_pkg::ST_DETECT: begin
				if (blank_r == `BLANK_CYCLES) begin
					state_nxt = buck_seq_pkg::ST_SOFT1;
				end
			end
			buck_seq_pkg::ST_SOFT1: begin
				if (rampNearBoot) begin
					state_nxt = buck_seq_pkg::ST_DELAY3;
				end
			end
			buck_seq_pkg::ST_DELAY3: begin
				if (timerDone) begin
					state_nxt = buck_seq_pkg::ST_SOFT2;
				end
			end
			buck_seq_pkg::ST_SOFT2: begin
				if (rampAtTarget) begin
					state_nxt = buck_seq_pkg::ST_DELAY5;
				end
			end
			buck_seq_pkg::ST_DELAY5: begin
				if (timerDone) begin
					state_nxt = buck_seq_pkg::ST_RUN;
				end
			end
			buck_seq_pkg::ST_RUN: begin
				if (overCurrent) begin
					state_nxt = buck_seq_pkg::ST_LATCHDLY;
				end
			end
			buck_seq_pkg::ST_LATCHDLY: begin
				if (timerDone) begin
					state_nxt = buck_seq_pkg::ST_LATCHED;
				end else if (!overCurrent) begin
					state_nxt = buck_seq_pkg::ST_RUN;
				end
			end
			buck_seq_pkg::ST_LATCHED: begin
				state_nxt = buck_seq_pkg::ST_LATCHED;
			end
			default: begin
				state_nxt = buck_seq_pkg::ST_OFF;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (rst || !enabled) begin
			state_r <= buck_seq_pkg::ST_OFF;
		end else begin
			state_r <= state_nxt;
		end
	end

	always_comb begin
		rampStep = `SLEW_SOFT_START;
		rampTarget = voltageIdCode;
		if (state_r == buck_seq_pkg::ST_SOFT1 || state_r == buck_seq_pkg::ST_DELAY3) begin
			rampTarget = CODE_W'(BOOT_LEVEL);
		end
		if (state_r == buck_seq_pkg::ST_RUN || state_r == buck_seq_pkg::ST_LATCHDLY) begin
			rampStep = `SLEW_DYNAMIC;
		end
	end

	assign rampClear = !enabled || state_r == buck_seq_pkg::ST_OFF
		|| state_r == buck_seq_pkg::ST_DELAY1 || state_r == buck_seq_pkg::ST_DETECT;

	ramp_slew_limiter #(
		.W(CODE_W)
	) u_ramp (
		.clk_sys(clk_sys),
		.rst    (rst),
		.clear  (rampClear),
		.tick   (oscTick),
		.step   (rampStep),
		.target (rampTarget),
		.level  (softStartRamp)
	);

	assign switching = enabled && (state_r == buck_seq_pkg::ST_SOFT1
		|| state_r == buck_seq_pkg::ST_DELAY3 || state_r == buck_seq_pkg::ST_SOFT2
		|| state_r == buck_seq_pkg::ST_DELAY5 || state_r == buck_seq_pkg::ST_RUN
		|| state_r == buck_seq_pkg::ST_LATCHDLY);

	always_ff @(posedge clk_sys) begin
		if (rst || !switching) begin
			pwmEnable <= 3'h0;
		end else begin
			pwmEnable <= pwmDemand & {phases_r == `MAX_PHASES, 2'h3};
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst || !enabled) begin
			powerGoodOut <= 1'b0;
			driverEnableOut <= 1'b0;
			errorAmpClamp <= 1'b0;
			loadReleaseDetect <= 1'b0;
		end else begin
			powerGoodOut <= outputInRange && (state_r == buck_seq_pkg::ST_RUN
				|| state_r == buck_seq_pkg::ST_LATCHDLY);
			driverEnableOut <= switching;
			errorAmpClamp <= overCurrent && switching;
			loadReleaseDetect <= loadRelease && switching;
		end
	end

	assign phaseCount = phases_r;
	assign latchedOff = (state_r == buck_seq_pkg::ST_LATCHED);

	// latched off state is held until disable
	property p_latch_hold;
		@(posedge clk_sys) disable iff (rst)
		(latchedOff && enabled) |=> latchedOff || !enabled;
	endproperty
	a_latch_hold: assert property (p_latch_hold) else $error("latch lost");

	property p_timer_zero;
		@(posedge clk_sys) disable iff (rst)
		!enabled |=> timer_r == '0;
	endproperty
	a_timer_zero: assert property (p_timer_zero) else $error("timer not zero");

	property p_pwm_off;
		@(posedge clk_sys) disable iff (rst)
		!enabled |=> pwmEnable == 3'h0 && !powerGoodOut && !driverEnableOut;
	endproperty
	a_pwm_off: assert property (p_pwm_off) else $error("outputs not off");

	property p_ramp_clear;
		@(posedge clk_sys) disable iff (rst)
		!enabled |=> softStartRamp == '0;
	endproperty
	a_ramp_clear: assert property (p_ramp_clear) else $error("ramp not cleared");

	property p_d1_gate;
		@(posedge clk_sys) disable iff (rst)
		(state_r == buck_seq_pkg::ST_DELAY1 && !timerDone) |=> state_r != buck_seq_pkg::ST_DETECT;
	endproperty
	a_d1_gate: assert property (p_d1_gate) else $error("early detect");

	property p_blank;
		@(posedge clk_sys) disable iff (rst)
		state_r == buck_seq_pkg::ST_DETECT |=> pwmEnable == 3'h0;
	endproperty
	a_blank: assert property (p_blank) else $error("pwm during blank");

	property p_no_early_latch;
		@(posedge clk_sys) disable iff (rst)
		(state_r == buck_seq_pkg::ST_SOFT2 && overCurrent) |=> state_r != buck_seq_pkg::ST_LATCHDLY;
	endproperty
	a_no_early_latch: assert property (p_no_early_latch) else $error("early latchoff");

	property p_latch_rate;
		@(posedge clk_sys) disable iff (rst)
		(state_r == buck_seq_pkg::ST_LATCHDLY && $past(state_r) == buck_seq_pkg::ST_LATCHDLY
			&& !timerDone && timer_r != '0) |-> timer_r == $past(timer_r) + TIMER_W'(`DELAY_RATE_LATCH);
	endproperty
	a_latch_rate: assert property (p_latch_rate) else $error("latch rate wrong");

	property p_resume;
		@(posedge clk_sys) disable iff (rst)
		(state_r == buck_seq_pkg::ST_LATCHDLY && !overCurrent && !timerDone && enabled)
			|=> state_r == buck_seq_pkg::ST_RUN ##1 timer_r == '0;
	endproperty
	a_resume: assert property (p_resume) else $error("no resume");

	property p_gate_off;
		@(posedge clk_sys) disable iff (rst)
		!enabled |=> state_r == buck_seq_pkg::ST_OFF;
	endproperty
	a_gate_off: assert property (p_gate_off) else $error("start without enable");

	// each start-up delay ends on threshold and hands back a zero timer
	property p_delay_end;
		@(posedge clk_sys) disable iff (rst)
		(enabled && timerDone && (state_r == buck_seq_pkg::ST_DELAY1
			|| state_r == buck_seq_pkg::ST_DELAY3 || state_r == buck_seq_pkg::ST_DELAY5))
			|=> state_r != $past(state_r) && timer_r == '0;
	endproperty
	a_delay_end: assert property (p_delay_end) else $error("delay not ended");

	property p_near_boot;
		@(posedge clk_sys) disable iff (rst)
		(state_r == buck_seq_pkg::ST_SOFT1 && rampNearBoot && enabled)
			|=> state_r == buck_seq_pkg::ST_DELAY3;
	endproperty
	a_near_boot: assert property (p_near_boot) else $error("boot hold not started");

	// code below boot level: ramp must walk down at soft-start rate
	property p_soft2_down;
		@(posedge clk_sys) disable iff (rst)
		(state_r == buck_seq_pkg::ST_SOFT2 && enabled && oscTick
			&& softStartRamp > voltageIdCode)
			|=> softStartRamp == $past(softStartRamp) - CODE_W'(`SLEW_SOFT_START);
	endproperty
	a_soft2_down: assert property (p_soft2_down) else $error("ramp not falling");

	property p_slew_fast;
		@(posedge clk_sys) disable iff (rst)
		(state_r == buck_seq_pkg::ST_RUN && enabled && oscTick && voltageIdCode > softStartRamp
			&& voltageIdCode - softStartRamp > CODE_W'(`SLEW_DYNAMIC))
			|=> softStartRamp == $past(softStartRamp) + CODE_W'(`SLEW_DYNAMIC);
	endproperty
	a_slew_fast: assert property (p_slew_fast) else $error("code step slew wrong");
endmodule

//--- inc/buck_seq_defs.svh
// timing and threshold constants for the buck start-up sequencer
`ifndef BUCK_SEQ_DEFS_SVH
`define BUCK_SEQ_DEFS_SVH
`define BLANK_CYCLES       3'h4
`define DELAY_RATE_START   3'h4
`define DELAY_RATE_LATCH   3'h1
`define SLEW_SOFT_START    3'h1
`define SLEW_DYNAMIC       3'h5
`define OSC_DIV_DEFAULT    16
`define MIN_PHASES         2'h2
`define MAX_PHASES         2'h3
`define CODE_WIDTH         8
`define TIMER_THRESH_DEF   12'h100
`define BOOT_LEVEL_DEF     8'h58
`define BOOT_WINDOW_DEF    8'h08
`endif

//--- inc/buck_seq_pkg.sv
// types shared by the buck start-up sequencer
package buck_seq_pkg;
	typedef enum logic [3:0] {
		ST_OFF,
		ST_DELAY1,
		ST_DETECT,
		ST_SOFT1,
		ST_DELAY3,
		ST_SOFT2,
		ST_DELAY5,
		ST_RUN,
		ST_LATCHDLY,
		ST_LATCHED
	} seq_state_e;
endpackage

//--- logic/osc_enable_divider.sv
// oscillator enable pulse divider, stopped while not running
`timescale 1ns/1ps
module osc_enable_divider #(
	parameter int DIV = 16
) (
	input  wire logic clk_sys,
	input  wire logic rst,
	input  wire logic run,
	output logic      oscTick
);
	logic [15:0] cnt_r;
	always_ff @(posedge clk_sys) begin
		if (rst || !run) begin
			cnt_r <= 16'h0000;
		end else if (cnt_r == 16'(DIV - 1)) begin
			cnt_r <= 16'h0000;
		end else begin
			cnt_r <= cnt_r + 16'h0001;
		end
	end
	assign oscTick = run && (cnt_r == 16'(DIV - 1));
endmodule

//--- logic/ramp_slew_limiter.sv
// soft-start ramp tracker with selectable slew step
`timescale 1ns/1ps
module ramp_slew_limiter #(
	parameter int W = 8
) (
	input  wire logic         clk_sys,
	input  wire logic         rst,
	input  wire logic         clear,
	input  wire logic         tick,
	input  wire logic [2:0]   step,
	input  wire logic [W-1:0] target,
	output logic [W-1:0]      level
);
	logic [W-1:0] diff;
	logic [W-1:0] stepW;
	assign stepW = W'(step);
	assign diff = (level > target) ? (level - target) : (target - level);
	always_ff @(posedge clk_sys) begin
		if (rst || clear) begin
			level <= '0;
		end else if (tick) begin
			if (diff <= stepW) begin
				level <= target;
			end else if (level < target) begin
				level <= level + stepW;
			end else begin
				level <= level - stepW;
			end
		end
	end
endmodule

//--- test/vid_source_model.sv
// far-side model: cpu voltage code source and modulator phase demand
`timescale 1ns/1ps
module cpu_code_source_model (
	input  wire logic       codeReq,
	input  wire logic [7:0] codeSet,
	input  wire logic       demandOn,
	output logic [7:0]      voltageIdCode,
	output logic [2:0]      pwmDemand
);
	// eight-bit code level
	// code is a plain level, no strobe, so it can change at any cycle
	assign voltageIdCode = codeReq ? codeSet : 8'h00;
	assign pwmDemand = demandOn ? 3'h7 : 3'h0;
endmodule

//--- test/buck_startup_latchoff_sequencer_tb.sv
// self-checking bench for the buck start-up sequencer
`timescale 1ns/1ps
module buck_startup_latchoff_sequencer_tb;
	logic       clk_sys       = 1'b0;
	logic       rst           = 1'b1;
	logic       enableIn      = 1'b0;
	logic       supplyLockout = 1'b0;
	logic [7:0] codeSet       = 8'h30;
	logic [2:0] phaseSensed   = 3'h7;
	logic       overCurrent   = 1'b0;
	logic       loadRelease   = 1'b0;
	logic       outputInRange = 1'b1;
	logic       demandOn      = 1'b1;
	logic [7:0] voltageIdCode;
	logic [2:0] pwmDemand;
	logic [2:0] pwmEnable;
	logic [1:0] phaseCount;
	logic [7:0] softStartRamp;
	logic       errorAmpClamp;
	logic       loadReleaseDetect;
	logic       powerGoodOut;
	logic       driverEnableOut;
	logic       latchedOff;
	int         num_errors      = 0;
	int         samples_checked = 0;

	always #5 clk_sys = ~clk_sys;

	cpu_code_source_model u_cpu (
		.codeReq      (1'b1),
		.codeSet      (codeSet),
		.demandOn     (demandOn),
		.voltageIdCode(voltageIdCode),
		.pwmDemand    (pwmDemand)
	);

	// short divider and threshold keep the run brief
	buck_startup_latchoff_sequencer #(.OSC_DIV(4), .TIMER_THRESH(12'h010)) u_dut (
		.clk_sys          (clk_sys),
		.rst              (rst),
		.enableIn         (enableIn),
		.supplyLockout    (supplyLockout),
		.voltageIdCode    (voltageIdCode),
		.phaseSensed      (phaseSensed),
		.overCurrent      (overCurrent),
		.loadRelease      (loadRelease),
		.outputInRange    (outputInRange),
		.pwmDemand        (pwmDemand),
		.pwmEnable        (pwmEnable),
		.phaseCount       (phaseCount),
		.softStartRamp    (softStartRamp),
		.errorAmpClamp    (errorAmpClamp),
		.loadReleaseDetect(loadReleaseDetect),
		.powerGoodOut     (powerGoodOut),
		.driverEnableOut  (driverEnableOut),
		.latchedOff       (latchedOff)
	);

	task automatic chk8(input string what, input logic [7:0] expv, input logic [7:0] got);
		samples_checked++;
		if (got !== expv) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, expv, got);
		end
	endtask

	task automatic chk1(input string what, input logic expv, input logic got);
		samples_checked++;
		if (got !== expv) begin
			num_errors++;
			$display("CHECK FAILED %s expected %b seen %b", what, expv, got);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge clk_sys);
	endtask

	task automatic end_of_test;
		if (num_errors == 0 && samples_checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// full start-up to the code, then a few cycles past the final delay
	task automatic power_up(input logic [7:0] code);
		int n;
		codeSet = code;
		enableIn = 1'b1;
		for (n = 0; n < 18; n++) begin
			cyc(1);
			chk8("pwmEnable", 8'h00, {5'h0, pwmEnable});
			chk8("softStartRamp", 8'h00, softStartRamp);
		end
		n = 0;
		// ramp passes low codes on its way to boot, so wait for power good instead
		while (powerGoodOut !== 1'b1 && n < 3000) begin
			cyc(1);
			n++;
		end
		chk8("softStartRamp", code, softStartRamp);
		chk1("driverEnableOut", 1'b1, driverEnableOut);
		chk1("latchedOff", 1'b0, latchedOff);
		cyc(8);
		chk8("phaseCount", phaseSensed[2] ? 8'h03 : 8'h02, {6'h0, phaseCount});
		chk8("pwmEnable", {5'h0, phaseSensed[2], 2'h3}, {5'h0, pwmEnable});
		chk1("powerGoodOut", 1'b1, powerGoodOut);
	endtask

	task automatic t_lockout;
		supplyLockout = 1'b1;
		enableIn = 1'b1;
		cyc(40);
		chk8("softStartRamp", 8'h00, softStartRamp);
		chk1("driverEnableOut", 1'b0, driverEnableOut);
		chk1("powerGoodOut", 1'b0, powerGoodOut);
		enableIn = 1'b0;
		supplyLockout = 1'b0;
		cyc(2);
	endtask

	task automatic t_run_release;
		power_up(8'h70);
		loadRelease = 1'b1;
		cyc(3);
		chk1("loadReleaseDetect", 1'b1, loadReleaseDetect);
		loadRelease = 1'b0;
		cyc(3);
		chk1("loadReleaseDetect", 1'b0, loadReleaseDetect);
		demandOn = 1'b0;
		cyc(2);
		chk8("pwmEnable", 8'h00, {5'h0, pwmEnable});
		demandOn = 1'b1;
		cyc(2);
		chk8("pwmEnable", 8'h07, {5'h0, pwmEnable});
	endtask

	// code step of 20 must go in steps of five
	task automatic t_slew;
		logic [7:0] prev;
		int         n;
		codeSet = 8'h84;
		for (n = 0; n < 20 && softStartRamp === 8'h70; n++) cyc(1);
		prev = softStartRamp;
		chk8("slew step", 8'h75, prev);
		for (n = 0; n < 20 && softStartRamp === prev; n++) cyc(1);
		chk8("slew step", 8'h7A, softStartRamp);
		cyc(20);
		chk8("softStartRamp", 8'h84, softStartRamp);
	endtask

	task automatic t_latch_clear;
		overCurrent = 1'b1;
		cyc(10);
		chk1("errorAmpClamp", 1'b1, errorAmpClamp);
		chk8("pwmEnable", 8'h07, {5'h0, pwmEnable});
		overCurrent = 1'b0;
		cyc(3);
		overCurrent = 1'b1;
		// a stale timer or full rate would already have latched here
		cyc(12);
		chk1("latchedOff", 1'b0, latchedOff);
		cyc(20);
		chk1("latchedOff", 1'b1, latchedOff);
		chk8("pwmEnable", 8'h00, {5'h0, pwmEnable});
		overCurrent = 1'b0;
		cyc(5);
		chk1("latchedOff", 1'b1, latchedOff);
		enableIn = 1'b0;
		cyc(3);
		chk1("latchedOff", 1'b0, latchedOff);
		chk8("softStartRamp", 8'h00, softStartRamp);
		chk1("powerGoodOut", 1'b0, powerGoodOut);
		chk1("driverEnableOut", 1'b0, driverEnableOut);
	endtask

	task automatic t_oc_startup;
		phaseSensed = 3'h3;
		overCurrent = 1'b1;
		power_up(8'h30);
		cyc(30);
		chk1("latchedOff", 1'b1, latchedOff);
		supplyLockout = 1'b1;
		cyc(3);
		chk1("latchedOff", 1'b0, latchedOff);
		chk8("softStartRamp", 8'h00, softStartRamp);
	endtask

	initial begin
		cyc(4);
		rst = 1'b0;
		cyc(2);
		t_lockout();
		t_run_release();
		t_slew();
		t_latch_clear();
		t_oc_startup();
		end_of_test();
	end

	// whole sequence needs well under 5000 cycles
	initial begin
		repeat (20000) @(posedge clk_sys);
		num_errors++;
		end_of_test();
	end
endmodule
